/* rtl/cfg_hdr_pkg.sv */
// Shared constants, types and register map of the bridge header bank
package cfg_hdr_pkg;

  // Register index width; byte address is four times the index
  localparam int IDX_W = 8;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;

  // Register indices, as printed
  localparam logic [IDX_W-1:0] IDX_PRI_LAT   = 8'h0D;
  localparam logic [IDX_W-1:0] IDX_HDR_TYPE  = 8'h0E;
  localparam logic [IDX_W-1:0] IDX_SELF_TEST = 8'h0F;
  localparam logic [IDX_W-1:0] IDX_BASE0     = 8'h10;
  localparam logic [IDX_W-1:0] IDX_BASE1     = 8'h14;
  localparam logic [IDX_W-1:0] IDX_UP_BUS    = 8'h18;
  localparam logic [IDX_W-1:0] IDX_DOWN_BUS  = 8'h19;
  localparam logic [IDX_W-1:0] IDX_HIGH_BUS  = 8'h1A;
  localparam logic [IDX_W-1:0] IDX_SEC_LAT   = 8'h1B;
  localparam logic [IDX_W-1:0] IDX_IO_BASE   = 8'h1C;
  localparam logic [IDX_W-1:0] IDX_IO_LIMIT  = 8'h1D;
  // Control and status of the block itself
  localparam logic [IDX_W-1:0] IDX_LOCK      = 8'h40;
  localparam logic [IDX_W-1:0] IDX_STATUS    = 8'h41;

  // Constant field values and reset values
  localparam logic [7:0]  LAT_CONST      = 8'h00;
  localparam logic [7:0]  HDR_TYPE_ONE   = 8'h01;
  localparam logic [7:0]  SELF_TEST_NONE = 8'h00;
  localparam logic [31:0] BASE_UNUSED    = 32'h0000_0000;
  localparam logic [7:0]  BUS_NUM_RST    = 8'h00;
  localparam logic [3:0]  IO_BASE_RST    = 4'hF;
  localparam logic [3:0]  IO_LIMIT_RST   = 4'h0;
  localparam logic [11:0] IO_LOW_FILL    = 12'h000;
  localparam logic [11:0] IO_HIGH_FILL   = 12'hFFF;
  localparam logic [15:0] UPPER_ZERO     = 16'h0000;

  // Field positions inside the I/O window bytes, the lock word and the status word
  localparam int IO_CAP_BIT = 0;
  localparam int IO_ADR_LSB = 4;
  localparam int IO_ADR_MSB = 7;
  localparam int LOCK_OPEN_BIT = 0;
  localparam int ST_HIT_BIT = 0;
  localparam int ST_EMPTY_BIT = 1;
  localparam int ST_MODE_BIT = 2;
  localparam int ST_CNT_LSB = 8;
  localparam int ST_CNT_MSB = 15;

  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;
  localparam logic [2:0] HSIZE_BYTE    = 3'h0;
  localparam logic [2:0] HSIZE_HALF    = 3'h1;

  typedef enum logic {
    sixteen_bit_io_mode    = 1'b0,
    thirty_two_bit_io_mode = 1'b1
  } io_mode_t;

  localparam io_mode_t IO_CAP_RST = thirty_two_bit_io_mode;

  typedef enum {ST_IDLE, ST_WRITE, ST_READ} port_state_t;

  // Register access handed from the bus port to the bank
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic              hit;
    logic [IDX_W-1:0]  idx;
    logic [3:0]        be;
    logic [DATA_W-1:0] wdata;
  } cfg_req_t;

  // One I/O address offered for a forwarding decision
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
  } io_check_t;

endpackage

/* rtl/ahb_cfg_port.sv */
// AHB-Lite slave front end that turns transfers into register accesses
`timescale 1ns/1ns
module ahb_cfg_port
  import cfg_hdr_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // AHB-Lite slave side
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [DATA_W-1:0] hwdata,
  output logic                   hreadyout_q,
  output logic [DATA_W-1:0]      hrdata_q,
  output logic                   hresp_q,
  // Register bank side
  output cfg_req_t               req,
  input  wire logic [DATA_W-1:0] rd_data
);

  port_state_t      state_q;
  logic [IDX_W-1:0] idx_q;
  logic [3:0]       be_q;
  logic             hit_q;
  logic             accept;

  assign accept = hsel && htrans == HTRANS_NONSEQ && hready;

  // Byte lanes touched by the transfer
  function automatic logic [3:0] lanes(input logic [2:0] sz,
                                       input logic [1:0] a);
    logic [3:0] m;
    m = 4'hF;
    if (sz == HSIZE_BYTE) m = 4'h1 << a;
    else if (sz == HSIZE_HALF) m = a[1] ? 4'hC : 4'h3;
    return m;
  endfunction

  // Address phase capture; reads take one wait state for registered data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      idx_q   <= '0;
      be_q    <= 4'h0;
      hit_q   <= 1'b0;
    end else if (accept) begin
      state_q <= hwrite ? ST_WRITE : ST_READ;
      idx_q   <= haddr[IDX_W+1:2];
      be_q    <= lanes(hsize, haddr[1:0]);
      hit_q   <= haddr[ADDR_W-1:IDX_W+2] == '0;
    end else begin
      state_q <= ST_IDLE;
    end
  end

  // Handshake and read data; response is always OKAY
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_q <= 1'b1;
      hrdata_q    <= '0;
      hresp_q     <= HRESP_OKAY;
    end else begin
      hreadyout_q <= !(accept && !hwrite);
      hresp_q     <= HRESP_OKAY;
      if (state_q == ST_READ) hrdata_q <= rd_data;
    end
  end

  // Data phase access to the bank
  always_comb begin
    req.wr    = state_q == ST_WRITE;
    req.rd    = state_q == ST_READ;
    req.hit   = hit_q;
    req.idx   = idx_q;
    req.be    = be_q;
    req.wdata = hwdata;
  end

endmodule

/* rtl/io_window_match.sv */
// Compares one I/O address against the programmed forwarding window
`timescale 1ns/1ns
module io_window_match
  import cfg_hdr_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Address under test and window bounds
  input  io_check_t       chk,
  input  wire logic [3:0] base_nib,
  input  wire logic [3:0] limit_nib,
  input  wire logic [15:0] base_upper,
  input  wire logic [15:0] limit_upper,
  input  io_mode_t        mode,
  // Decision, one cycle after the request
  output logic            done_q,
  output logic            hit_q
);

  logic [15:0] lo;
  logic [15:0] hi;
  logic [15:0] up_lo;
  logic [15:0] up_hi;
  logic        in_win;

  // Window edges: 4KB aligned start, limit filled with ones below
  always_comb begin
    lo     = {base_nib, IO_LOW_FILL};
    hi     = {limit_nib, IO_HIGH_FILL};
    // Narrow decode treats the upper half of both bounds as zero
    up_lo  = (mode == thirty_two_bit_io_mode) ? base_upper : UPPER_ZERO;
    up_hi  = (mode == thirty_two_bit_io_mode) ? limit_upper : UPPER_ZERO;
    in_win = {chk.addr[31:16], chk.addr[15:0]} >= {up_lo, lo} &&
             {chk.addr[31:16], chk.addr[15:0]} <= {up_hi, hi};
  end

  // Registered decision; a base above the limit never matches
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      hit_q  <= 1'b0;
    end else begin
      done_q <= chk.valid;
      hit_q  <= chk.valid && in_win;
    end
  end

endmodule

/* rtl/bridge_type1_header_bus_io_regs.sv */
// Bridge header bank: constants, bus numbers and the I/O window
//
// How it works
// - Both latency timer bytes read constant zero
// - Header type byte reads constant 0x01
// - Self-test byte reads constant zero
// - Both base address words read zero
// - Upstream bus number: writable byte, reset zero
// - Downstream bus number: writable byte, reset zero
// - Highest bus behind: writable byte, reset zero
// - Width flag bit 0, resets 1, lock guarded
// - Limit bit 0 mirrors the width flag
// - Base bits 7:4 hold A15:12, reset 0xF
// - Limit bits 7:4, reset 0, low bits ones
// - Forward I/O only inside base-limit window
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module bridge_type1_header_bus_io_regs
  import cfg_hdr_pkg::*;
#(
  parameter int BUS_REGS = 3
)
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,

  // AHB-Lite register port
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [DATA_W-1:0] hwdata,
  output logic                   hreadyout,
  output logic [DATA_W-1:0]      hrdata,
  output logic                   hresp,

  // I/O forwarding check from the switch core
  input  wire logic              io_chk_valid,
  input  wire logic [ADDR_W-1:0] io_chk_addr,
  input  wire logic [15:0]       io_base_upper,
  input  wire logic [15:0]       io_limit_upper,
  output logic                   io_fwd_valid,
  output logic                   io_fwd_hit
);

  // ------------------------------------------------------------
  // Bus port
  // ------------------------------------------------------------

  cfg_req_t          req;
  logic [DATA_W-1:0] rd_data;
  logic              hreadyout_q;
  logic [DATA_W-1:0] hrdata_q;
  logic              hresp_q;

  ahb_cfg_port u_port (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .hsel        (hsel),
    .haddr       (haddr),
    .htrans      (htrans),
    .hwrite      (hwrite),
    .hsize       (hsize),
    .hready      (hready),
    .hwdata      (hwdata),
    .hreadyout_q (hreadyout_q),
    .hrdata_q    (hrdata_q),
    .hresp_q     (hresp_q),
    .req         (req),
    .rd_data     (rd_data)
  );

  // Bus outputs come from the port's flip-flops
  assign hreadyout = hreadyout_q;
  assign hrdata    = hrdata_q;
  assign hresp     = hresp_q;

  // ------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------

  // Every writable field sits in byte lane 0, so only that lane writes.
  // Unmapped addresses and read-only indices fall through silently.
  logic wr_lane0;
  logic wr_lock;
  logic wr_io_base;
  logic wr_io_limit;

  assign wr_lane0    = req.wr && req.hit && req.be[0];
  assign wr_lock     = wr_lane0 && req.idx == IDX_LOCK;
  assign wr_io_base  = wr_lane0 && req.idx == IDX_IO_BASE;
  assign wr_io_limit = wr_lane0 && req.idx == IDX_IO_LIMIT;

  // ------------------------------------------------------------
  // Bus number bytes
  // ------------------------------------------------------------

  // Upstream, downstream and highest-behind numbers, in index order.
  // They only hold what software writes; nothing here routes by them.
  logic [7:0] bus_num_q [BUS_REGS];

  genvar g;
  generate
    for (g = 0; g < BUS_REGS; g++) begin : g_bus
      localparam logic [IDX_W-1:0] MY_IDX =
        IDX_W'(IDX_UP_BUS + IDX_W'(g));

      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          bus_num_q[g] <= BUS_NUM_RST;
        end else if (wr_lane0 && req.idx == MY_IDX) begin
          bus_num_q[g] <= req.wdata[7:0];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Lock control
  // ------------------------------------------------------------

  // The width flag is lock guarded: it changes only while software
  // has opened the lock. Reset leaves it closed so a stray write
  // cannot narrow the decode.
  logic lock_open_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_open_q <= 1'b0;
    end else if (wr_lock) begin
      lock_open_q <= req.wdata[LOCK_OPEN_BIT];
    end
  end

  // ------------------------------------------------------------
  // I/O window base and limit
  // ------------------------------------------------------------

  io_mode_t   io_mode_q;
  logic [3:0] io_base_q;
  logic [3:0] io_limit_q;

  // Addressing width flag, kept in the base byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_mode_q <= IO_CAP_RST;
    end else if (wr_io_base && lock_open_q) begin
      io_mode_q <= io_mode_t'(req.wdata[IO_CAP_BIT]);
    end
  end

  // Window start, A15:12; bits 3:1 of the byte are not stored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_base_q <= IO_BASE_RST;
    end else if (wr_io_base) begin
      io_base_q <= req.wdata[IO_ADR_MSB:IO_ADR_LSB];
    end
  end

  // Window end, A15:12; bit 0 of this byte is never written
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_limit_q <= IO_LIMIT_RST;
    end else if (wr_io_limit) begin
      io_limit_q <= req.wdata[IO_ADR_MSB:IO_ADR_LSB];
    end
  end

  // ------------------------------------------------------------
  // Forwarding decision
  // ------------------------------------------------------------

  // The check port comes from core logic on this clock, so it needs
  // no synchroniser. The decision lags the request by one cycle.
  io_check_t chk;
  logic      match_done;
  logic      match_hit;

  assign chk.valid = io_chk_valid;
  assign chk.addr  = io_chk_addr;

  io_window_match u_match (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .chk         (chk),
    .base_nib    (io_base_q),
    .limit_nib   (io_limit_q),
    .base_upper  (io_base_upper),
    .limit_upper (io_limit_upper),
    .mode        (io_mode_q),
    .done_q      (match_done),
    .hit_q       (match_hit)
  );

  assign io_fwd_valid = match_done;
  assign io_fwd_hit   = match_hit;

  // ------------------------------------------------------------
  // Decision history for software
  // ------------------------------------------------------------

  // Last decision and a wrapping count of forwarded accesses.
  // The count is diagnostic only, so wrap beats a saturate compare.
  logic       last_hit_q;
  logic [7:0] hit_cnt_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_hit_q <= 1'b0;
    end else if (match_done) begin
      last_hit_q <= match_hit;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hit_cnt_q <= 8'h00;
    end else if (match_done && match_hit) begin
      hit_cnt_q <= hit_cnt_q + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Read assembly
  // ------------------------------------------------------------

  logic [7:0]        io_base_byte;
  logic [7:0]        io_limit_byte;
  logic [DATA_W-1:0] status_word;

  // Reserved bits 3:1 of both window bytes read as zero
  always_comb begin
    io_base_byte = 8'h00;
    io_base_byte[IO_CAP_BIT] = io_mode_q;
    io_base_byte[IO_ADR_MSB:IO_ADR_LSB] = io_base_q;
    io_limit_byte = 8'h00;
    io_limit_byte[IO_CAP_BIT] = io_mode_q;
    io_limit_byte[IO_ADR_MSB:IO_ADR_LSB] = io_limit_q;
  end

  // Block status: last decision, empty window, decode width, count
  always_comb begin
    status_word = '0;
    status_word[ST_HIT_BIT]   = last_hit_q;
    status_word[ST_EMPTY_BIT] = io_base_q > io_limit_q;
    status_word[ST_MODE_BIT]  = io_mode_q;
    status_word[ST_CNT_MSB:ST_CNT_LSB] = hit_cnt_q;
  end

  // Narrow registers sit in the low bits; all else reads zero
  always_comb begin
    rd_data = '0;
    if (req.hit) begin
      unique case (req.idx)
        IDX_PRI_LAT:   rd_data[7:0] = LAT_CONST;
        IDX_SEC_LAT:   rd_data[7:0] = LAT_CONST;
        IDX_HDR_TYPE:  rd_data[7:0] = HDR_TYPE_ONE;
        IDX_SELF_TEST: rd_data[7:0] = SELF_TEST_NONE;
        IDX_BASE0:     rd_data = BASE_UNUSED;
        IDX_BASE1:     rd_data = BASE_UNUSED;
        IDX_UP_BUS:    rd_data[7:0] = bus_num_q[0];
        IDX_DOWN_BUS:  rd_data[7:0] = bus_num_q[1];
        IDX_HIGH_BUS:  rd_data[7:0] = bus_num_q[2];
        IDX_IO_BASE:   rd_data[7:0] = io_base_byte;
        IDX_IO_LIMIT:  rd_data[7:0] = io_limit_byte;
        IDX_LOCK:      rd_data[LOCK_OPEN_BIT] = lock_open_q;
        IDX_STATUS:    rd_data = status_word;
        default:       rd_data = '0;
      endcase
    end
  end

endmodule

/* tb/bridge_hdr_props.sv */
// Concurrent checks on the ports of the bridge header bank
`timescale 1ns/1ns
module bridge_hdr_props (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Forwarding check
  input wire logic        io_chk_valid,
  input wire logic        io_fwd_valid,
  input wire logic        io_fwd_hit
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // A transfer is taken only while the bus is ready
  sequence taken;
    hsel && hready && htrans[1];
  endsequence
  sequence rd_at(logic [31:0] a);
    taken ##0 !hwrite && haddr == a;
  endsequence
  // Constant words answer two edges after the read is taken
  property const_rd(logic [31:0] a, logic [31:0] v);
    rd_at(a) |-> ##2 hrdata == v;
  endproperty

  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_read_wait: assert property (taken ##0 !hwrite |=> !hreadyout)
    else $error("read without wait state");
  a_wait_one: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  a_write_nowait: assert property (taken ##0 hwrite |=> hreadyout)
    else $error("write stalled");
  a_fwd_timely: assert property (io_chk_valid |=> io_fwd_valid)
    else $error("no decision after check");
  a_fwd_caused: assert property (io_fwd_valid |-> $past(io_chk_valid))
    else $error("decision without check");
  a_hit_gated: assert property (io_fwd_hit |-> io_fwd_valid)
    else $error("hit without decision");
  a_hdr_type: assert property (const_rd(32'h38, 32'h1))
    else $error("header type wrong");
  a_lat_primary: assert property (const_rd(32'h34, 32'h0))
    else $error("primary latency not zero");
  a_lat_second: assert property (const_rd(32'h6C, 32'h0))
    else $error("secondary latency not zero");
  a_self_test: assert property (const_rd(32'h3C, 32'h0))
    else $error("self test not zero");
  a_bar_low: assert property (const_rd(32'h40, 32'h0))
    else $error("base word zero not zero");
  a_bar_high: assert property (const_rd(32'h50, 32'h0))
    else $error("base word one not zero");
endmodule

bind bridge_type1_header_bus_io_regs bridge_hdr_props i_props (
  .sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
  .hrdata, .hresp, .io_chk_valid, .io_fwd_valid, .io_fwd_hit
);

/* tb/host_cfg_model.sv */
// Host side model: single word transfers on the register bus
`timescale 1ns/1ns
module host_cfg_model
  import cfg_hdr_pkg::*;
(
  // Clock and bus answer
  input  wire logic        sys_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Bus request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // Bus idle at time zero, whole words only
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One transfer; released lines flip so stale values never look valid
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    haddr <= ~a;
    hwdata <= wr ? d : ~hwdata;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask
endmodule

/* tb/bridge_type1_header_bus_io_regs_bench.sv */
// Self-checking bench for the bridge header bank
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  failures++; $display("BAD %0t got %h exp %h", $time, got, exp); end end
module bridge_type1_header_bus_io_regs_bench;
  logic        sys_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        io_chk_valid;
  logic [31:0] io_chk_addr;
  logic [15:0] io_base_upper;
  logic [15:0] io_limit_upper;
  logic        io_fwd_valid;
  logic        io_fwd_hit;
  int          failures = 0;
  int          samples_checked = 0;
  // Byte addresses, reset values, and values after writing FFFF_FF2E
  logic [31:0] ra [11] = '{32'h34, 32'h38, 32'h3C, 32'h40, 32'h50, 32'h60,
                           32'h64, 32'h68, 32'h6C, 32'h70, 32'h74};
  logic [31:0] rv [11] = '{0, 1, 0, 0, 0, 0, 0, 0, 0, 32'hF1, 32'h01};
  logic [31:0] wv [11] = '{0, 1, 0, 0, 0, 32'h2E, 32'h2E, 32'h2E, 0,
                           32'h21, 32'h21};

  // Clock at 125 MHz
  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  bridge_type1_header_bus_io_regs i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .io_chk_valid(io_chk_valid), .io_chk_addr(io_chk_addr),
    .io_base_upper(io_base_upper), .io_limit_upper(io_limit_upper),
    .io_fwd_valid(io_fwd_valid), .io_fwd_hit(io_fwd_hit)
  );

  host_cfg_model i_host (
    .sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata)
  );

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask

  // One forwarding decision, looked at in the cycle it stands
  task automatic io_chk(input logic [31:0] a, input logic e);
    @(posedge sys_clk);
    io_chk_valid <= 1'b1;
    io_chk_addr <= a;
    @(posedge sys_clk);
    io_chk_valid <= 1'b0;
    io_chk_addr <= ~a;
    #1;
    `CHK(io_fwd_valid, 1'b1)
    `CHK(io_fwd_hit, e)
  endtask

  task automatic report_and_stop;
    if (failures == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #40000;
    failures++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    io_chk_valid = 1'b0;
    io_chk_addr = 32'h0;
    io_base_upper = 16'h0;
    io_limit_upper = 16'h0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 11; i++) rd_chk(ra[i], rv[i]);
    // Lock closed: width flag and constant words keep their values
    for (int i = 0; i < 11; i++) begin
      wr(ra[i], 32'hFFFF_FF2E);
      rd_chk(ra[i], wv[i]);
    end
    // Window 2000..2FFF, 32-bit mode, upper halves zero
    io_chk(32'h1FFF, 1'b0);
    io_chk(32'h2000, 1'b1);
    io_chk(32'h2FFF, 1'b1);
    io_chk(32'h3000, 1'b0);
    io_chk(32'h12000, 1'b0);
    // Upper halves change on an edge, like every other input
    @(posedge sys_clk);
    io_base_upper <= 16'h0001;
    io_limit_upper <= 16'h0001;
    io_chk(32'h12000, 1'b1);
    io_chk(32'h2000, 1'b0);
    // Lock open: switch to 16-bit mode
    wr(32'h100, 32'h1);
    wr(32'h70, 32'h20);
    rd_chk(32'h70, 32'h20);
    rd_chk(32'h74, 32'h20);
    io_chk(32'h2000, 1'b1);
    io_chk(32'h12000, 1'b0);
    // Lock closed again: flag stays put
    wr(32'h100, 32'h0);
    wr(32'h70, 32'h71);
    rd_chk(32'h70, 32'h70);
    rd_chk(32'h200, 32'h0);
    rd_chk(32'h400, 32'h0);
    // Status: four hits, last missed, base 7 above limit 2, 16-bit mode
    rd_chk(32'h104, 32'h0000_0402);
    // Second reset in mid-run restores defaults
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(32'h60, 32'h0);
    rd_chk(32'h70, 32'hF1);
    rd_chk(32'h74, 32'h01);
    // Status after reset: empty window, 32-bit mode, no hits
    rd_chk(32'h104, 32'h0000_0006);
    report_and_stop();
  end
endmodule
